// *** tb/smbus_address_and_alert_tb.sv ***
// self-checking bench: strap decode, mask register, alert masks and time-out
`timescale 1ns/1ps
module smbus_address_and_alert_tb;
  import smbus_alert_pkg::*;
  logic clk_in = 1'b0, link_clk_in = 1'b0, rst_b_in = 1'b0;
  logic [2:0] rdy = 3'h0;
  logic [15:0] fault_in = 16'h0000;
  logic [1:0] tie [3] = '{2'h0, 2'h0, 2'h0};
  logic [2:0] s_in, s_out, s_oe;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, host_scl_low, host_sda_low, alert, alert_oe, a;
  logic [7:0] d;
  logic [15:0] v;
  logic [6:0] own;
  slave_addr_t slave_addr;
  int num_errors = 0, samples_checked = 0;
  wire scl = !(host_scl_low || scl_oe_out);
  wire sda = !(host_sda_low || sda_oe_out);
  always #10 clk_in = !clk_in;
  always #7.5 link_clk_in = !link_clk_in;
  // a tie overrides the probe drive; a floating pin follows it or shows the inverse
  function automatic logic res(input logic [1:0] t, input logic o, input logic e);
    return (t == 2'h2) ? 1'b1 : (t == 2'h1) ? 1'b0 : (e ? o : !o);
  endfunction
  for (genvar g = 0; g < 3; g++) begin : g_strap
    assign s_in[g] = res(tie[g], s_out[g], s_oe[g]);
  end
  smbus_address_and_alert #(.TIMEOUT_CYCLES(2000), .STRETCH_CYCLES(2000)) smbus_address_and_alert_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in), .enable_in(rdy[0]),
    .vdd_por_b_in(rdy[1]), .vref_por_b_in(rdy[2]), .fault_in(fault_in),
    .addr_strap_bit_low_in(s_in[0]), .addr_strap_bit_low_out(s_out[0]), .addr_strap_bit_low_oe_out(s_oe[0]),
    .addr_strap_bit_mid_in(s_in[1]), .addr_strap_bit_mid_out(s_out[1]), .addr_strap_bit_mid_oe_out(s_oe[1]),
    .addr_strap_bit_high_in(s_in[2]), .addr_strap_bit_high_out(s_out[2]), .addr_strap_bit_high_oe_out(s_oe[2]),
    .scl_in(scl), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .host_alert_line_out(alert), .host_alert_line_oe_out(alert_oe),
    .slave_addr_out(slave_addr));
  smbus_host_model smbus_host_model_inst (.scl_in(scl), .sda_in(sda), .scl_low_out(host_scl_low),
    .sda_low_out(host_sda_low));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  function automatic logic [6:0] exp_addr(input int i);
    return (i < 8) ? 7'(8'h40 + i) : (i < 16) ? 7'(8'h10 + i - 8) : 7'(8'h50 + i - 16);
  endfunction
  task automatic head(input logic [7:0] c);
    smbus_host_model_inst.start();
    smbus_host_model_inst.wbyte({own, 1'b0}, a);
    check(a, 1'b1);
    smbus_host_model_inst.wbyte(c, a);
  endtask
  task automatic wr_mask(input logic [15:0] m);
    head(ALERT_MASK_CMD);
    smbus_host_model_inst.wbyte(m[7:0], a);
    smbus_host_model_inst.wbyte(m[15:8], a);
    smbus_host_model_inst.stop();
    wt(10);
  endtask
  task automatic rd_mask(input logic [15:0] exp);
    head(ALERT_MASK_CMD);
    smbus_host_model_inst.start();
    smbus_host_model_inst.wbyte({own, 1'b1}, a);
    smbus_host_model_inst.rbyte(v[7:0], 1'b1);
    smbus_host_model_inst.rbyte(v[15:8], 1'b0);
    smbus_host_model_inst.stop();
    check(v, exp);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #1500us num_errors++;
    end_of_test();
  end
  initial begin
    wt(6);
    rst_b_in = 1'b1;
    for (int i = 0; i < 27; i++) begin
      rdy = ~(3'h1 << (i % 3));
      wt(5);
      check(slave_addr.valid, 1'b0);
      tie = '{2'(i % 3), 2'((i / 3) % 3), 2'(i / 9)};
      rdy = 3'h7;
      wt(60);
      check(slave_addr, {1'b1, exp_addr(i)});
    end
    check({s_oe, s_out}, 6'h00);
    own = exp_addr(26);
    rd_mask(ALERT_MASK_RESET);
    smbus_host_model_inst.start();
    smbus_host_model_inst.wbyte(8'hfe, a);
    check(a, 1'b0);
    smbus_host_model_inst.stop();
    wt(1);
    fault_in = 16'h0001;
    wt(5);
    check({alert_oe, alert}, 2'h2);
    wr_mask(16'h0001);
    check(alert_oe, 1'b0);
    rd_mask(16'h0001);
    wr_mask(16'hffff);
    check(alert_oe, 1'b0);
    wr_mask(16'h0000);
    check(alert_oe, 1'b1);
    smbus_host_model_inst.start();
    smbus_host_model_inst.wbyte({ARA_ADDR, 1'b1}, a);
    check(a, 1'b1);
    smbus_host_model_inst.rbyte(d, 1'b0);
    smbus_host_model_inst.stop();
    check(d, {own, 1'b0});
    wt(5);
    check(alert_oe, 1'b0);
    fault_in = 16'h0003;
    wt(5);
    check(alert_oe, 1'b1);
    fault_in = 16'h0001;
    wt(5);
    check(alert_oe, 1'b0);
    head(CLEAR_FAULTS_CMD);
    smbus_host_model_inst.stop();
    wt(10);
    check(alert_oe, 1'b1);
    smbus_host_model_inst.start();
    smbus_host_model_inst.wbyte({ARA_ADDR, 1'b1}, a);
    for (int i = 0; i < 9; i++) begin
      smbus_host_model_inst.clk_bit(i == 8, a);
    end
    smbus_host_model_inst.stop();
    check(alert_oe, 1'b1);
    d = {own, 1'b0};
    smbus_host_model_inst.start();
    for (int i = 7; i >= 0; i--) begin
      smbus_host_model_inst.clk_bit(d[i], a);
    end
    wt(10);
    check(sda_oe_out, 1'b1);
    wt(1980);
    check(sda_oe_out, 1'b1);
    wt(120);
    check({scl_out, sda_out, scl_oe_out, sda_oe_out}, 4'h0);
    smbus_host_model_inst.stop();
    end_of_test();
  end
endmodule

// *** tb/smbus_host_model.sv ***
// behavioural smbus host that sits on the far side of the bus
`timescale 1ns/1ps
module smbus_host_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low_out,
  output logic sda_low_out
);
  // half period of a 400 kHz clock, the top of the allowed range
  localparam time HALF = 1250;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // data moves 300 ns after the clock falls so it never looks like a start or stop
  task automatic clk_bit(input logic b, output logic r);
    #300 sda_low_out = !b;
    #(HALF - 300) scl_low_out = 1'b0;
    // our own low phase stays short; a stretching target holds us here
    wait (scl_in);
    #HALF r = sda_in;
    scl_low_out = 1'b1;
  endtask
  task automatic start();
    #300 sda_low_out = 1'b0;
    #HALF scl_low_out = 1'b0;
    #HALF sda_low_out = 1'b1;
    #HALF scl_low_out = 1'b1;
  endtask
  task automatic stop();
    #300 sda_low_out = 1'b1;
    #HALF scl_low_out = 1'b0;
    #HALF sda_low_out = 1'b0;
    #(HALF * 2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(!ack, r);
  endtask
endmodule

// *** verilog/bit_sync.sv ***
// two-stage synchroniser for levels and toggles entering a clock domain
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in) begin
    meta <= d_in;
  end

  always_ff @(posedge clk_in) begin
    q_out <= meta;
  end
endmodule

// *** verilog/smbus_address_and_alert.sv ***
// smbus target front end: strap address, time-outs, alert masks and a small command engine
//
// Contract
// [R1] each strap pin reads high, low or floating; three pins give 27 addresses
// [R2] straps are sampled only once enable is high and both supplies left reset
// [R3] the decoded address is 7 bits; the eighth bus bit is read or write
// [R4] index msb pin first, float-low-high; maps to 40h-47h, 10h-17h, 50h-5Ah
// [R5] bus clock runs from 10 kHz to 400 kHz and the device works across it
// [R6] clock low over 25 ms is a time-out; interface resets before 35 ms
// [R7] slave stretch at most 25 ms per message, else release lines and reset
// [R8] host may extend its clock low at most 10 ms per byte segment
// [R9] alert is gated by the software mask at command d8h and the automatic mask
// [R10] alert response read counts only if our address wins arbitration
// [R11] winning an alert response read sets automatic mask for faults present
// [R12] automatic mask leaves status intact; masked faults stay off alert until cleared
// [R13] only a clear-faults command to this device clears the automatic mask
// [R14] alert is open-drain active low, driven while any unmasked fault is present
`timescale 1ns/1ps
module smbus_address_and_alert
  import smbus_alert_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned STRETCH_CYCLES = STRETCH_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic link_clk_in,
  input wire logic enable_in,
  input wire logic vdd_por_b_in,
  input wire logic vref_por_b_in,
  input wire logic [15:0] fault_in,
  input wire logic addr_strap_bit_low_in,
  output logic addr_strap_bit_low_out,
  output logic addr_strap_bit_low_oe_out,
  input wire logic addr_strap_bit_mid_in,
  output logic addr_strap_bit_mid_out,
  output logic addr_strap_bit_mid_oe_out,
  input wire logic addr_strap_bit_high_in,
  output logic addr_strap_bit_high_out,
  output logic addr_strap_bit_high_oe_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic host_alert_line_out,
  output logic host_alert_line_oe_out,
  output slave_addr_t slave_addr_out
);
  // --------------------------------------------------------------------------
  // core domain crossings and strap decode
  // --------------------------------------------------------------------------
  logic [8:0] c_s;
  logic c_scl, c_ready, c_ara, c_clr, c_mask, c_busy, c_stretch;
  logic ara_tog, clr_tog, mask_tog, lbusy, abort_tog;
  logic [2:0] strap_out, strap_oe;
  logic ara_seen, clr_seen, mask_seen, ara_evt, clr_evt, mask_evt;
  logic [15:0] fault_alert_enable_mask, mask_c, auto_alert_suppress;
  logic alert_on, drive_low_c;
  logic [31:0] low_cnt, stretch_cnt;

  bit_sync #(.W(9)) core_sync (
    .clk_in(clk_in),
    .d_in({scl_in, enable_in, vdd_por_b_in, vref_por_b_in, ara_tog, clr_tog, mask_tog, lbusy, scl_oe_out}),
    .q_out(c_s)
  );
  assign c_scl = c_s[8];
  assign c_ready = c_s[7] & c_s[6] & c_s[5];
  assign c_ara = c_s[4];
  assign c_clr = c_s[3];
  assign c_mask = c_s[2];
  assign c_busy = c_s[1];
  assign c_stretch = c_s[0];

  strap_addr_decode strap (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ready_in(c_ready), // [R2]
    .strap_pin_in({addr_strap_bit_high_in, addr_strap_bit_mid_in, addr_strap_bit_low_in}),
    .strap_pin_out(strap_out),
    .strap_pin_oe_out(strap_oe),
    .slave_addr_out(slave_addr_out)
  );
  assign {addr_strap_bit_high_out, addr_strap_bit_mid_out, addr_strap_bit_low_out} = strap_out;
  assign {addr_strap_bit_high_oe_out, addr_strap_bit_mid_oe_out, addr_strap_bit_low_oe_out} = strap_oe;

  // --------------------------------------------------------------------------
  // alert masking
  // --------------------------------------------------------------------------
  assign ara_evt = c_ara != ara_seen;
  assign clr_evt = c_clr != clr_seen;
  assign mask_evt = c_mask != mask_seen;

  // clr_seen doubles as the acknowledge that ends the link-side stretch
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ara_seen <= 1'b0;
      clr_seen <= 1'b0;
      mask_seen <= 1'b0;
    end else begin
      ara_seen <= c_ara;
      clr_seen <= c_clr;
      mask_seen <= c_mask;
    end
  end

  // the link copy only changes once per written word, far slower than the toggle crossing
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mask_c <= ALERT_MASK_RESET;
    end else if (mask_evt) begin
      mask_c <= fault_alert_enable_mask; // [R9]
    end
  end

  // a response win in the same cycle as a clear still masks the faults present
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      auto_alert_suppress <= 16'h0000;
    end else if (ara_evt) begin
      auto_alert_suppress <= (clr_evt ? 16'h0000 : auto_alert_suppress) | fault_in; // [R11] [R12]
    end else if (clr_evt) begin
      auto_alert_suppress <= 16'h0000; // [R13]
    end
  end

  // fault_in itself is never touched here, so status stays visible
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      alert_on <= 1'b0;
      drive_low_c <= 1'b0;
    end else begin
      alert_on <= |(fault_in & ~mask_c & ~auto_alert_suppress); // [R9] [R12] [R14]
      drive_low_c <= 1'b0;
    end
  end
  assign host_alert_line_oe_out = alert_on; // [R14]
  assign host_alert_line_out = drive_low_c;

  // --------------------------------------------------------------------------
  // clock-low time-out and cumulative stretch limit
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || c_scl || !c_busy) begin
      low_cnt <= 32'h0;
    end else if (low_cnt != TIMEOUT_CYCLES) begin
      low_cnt <= low_cnt + 32'h1; // [R6]
    end
  end

  // cumulative across the message; only the end of the message clears it
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !c_busy) begin
      stretch_cnt <= 32'h0;
    end else if (c_stretch && stretch_cnt != STRETCH_CYCLES) begin
      stretch_cnt <= stretch_cnt + 32'h1; // [R7]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      abort_tog <= 1'b0;
    end else if ((c_busy && !c_scl && low_cnt == TIMEOUT_CYCLES - 1) ||
                 (c_busy && c_stretch && stretch_cnt == STRETCH_CYCLES - 1)) begin
      abort_tog <= ~abort_tog; // [R6] [R7]
    end
  end

  // --------------------------------------------------------------------------
  // link domain: oversampled bus lines
  // --------------------------------------------------------------------------
  logic [6:0] l_s;
  logic l_scl, l_sda, l_rst_b, l_alert, l_clr_ack, l_abort, l_valid;
  logic scl_d, sda_d, abort_seen, rw, ara_sel, wr_idx, drive_low_l;
  logic start_c, stop_c, rise, fall, abort_c, own_hit;
  logic [3:0] bitcnt;
  logic [7:0] shreg, cmd, tx, mask_lo;
  link_state_t lstate;

  // link clock oversamples the bus far above 400 kHz, so any legal bus rate is followed
  bit_sync #(.W(7)) link_sync (
    .clk_in(link_clk_in),
    .d_in({scl_in, sda_in, rst_b_in, alert_on, clr_seen, abort_tog, slave_addr_out.valid}),
    .q_out(l_s)
  ); // [R5]
  assign {l_scl, l_sda, l_rst_b, l_alert, l_clr_ack, l_abort, l_valid} = l_s;

  assign start_c = scl_d & l_scl & sda_d & ~l_sda;
  assign stop_c = scl_d & l_scl & ~sda_d & l_sda;
  assign rise = l_scl & ~scl_d;
  assign fall = ~l_scl & scl_d;
  assign abort_c = l_abort != abort_seen;
  assign own_hit = l_valid && shreg[7:1] == slave_addr_out.addr; // [R3]

  always_ff @(posedge link_clk_in) begin
    if (!l_rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      lbusy <= 1'b0;
      drive_low_l <= 1'b0;
    end else begin
      scl_d <= l_scl;
      sda_d <= l_sda;
      lbusy <= lstate != L_IDLE;
      drive_low_l <= 1'b0;
    end
  end
  assign scl_out = drive_low_l;
  assign sda_out = drive_low_l;

  // --------------------------------------------------------------------------
  // link domain: byte engine
  // --------------------------------------------------------------------------
  always_ff @(posedge link_clk_in) begin
    if (!l_rst_b) begin
      lstate <= L_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      ara_sel <= 1'b0;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
      ara_tog <= 1'b0;
      clr_tog <= 1'b0;
      abort_seen <= 1'b0;
    end else if (abort_c) begin
      abort_seen <= l_abort;
      lstate <= L_IDLE; // [R6] [R7]
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
    end else if (stop_c) begin
      lstate <= L_IDLE;
      sda_oe_out <= 1'b0;
    end else if (start_c) begin
      lstate <= L_ADDR;
      bitcnt <= 4'h0;
      sda_oe_out <= 1'b0;
    end else begin
      case (lstate)
        L_ADDR, L_CMD, L_WR: begin
          if (rise) begin
            shreg <= {shreg[6:0], l_sda};
            bitcnt <= bitcnt + 4'h1;
          end else if (fall && bitcnt == 4'h8) begin
            if (lstate == L_ADDR) begin
              if (own_hit || (shreg[7:1] == ARA_ADDR && shreg[0] && l_alert)) begin
                sda_oe_out <= 1'b1;
                rw <= shreg[0]; // [R3]
                ara_sel <= !own_hit;
                tx <= !own_hit ? {slave_addr_out.addr, 1'b0} :
                      (cmd == ALERT_MASK_CMD ? fault_alert_enable_mask[7:0] : UNMAPPED_READ);
                lstate <= L_ADDR_ACK;
              end else begin
                lstate <= L_IDLE;
              end
            end else begin
              if (lstate == L_CMD) begin
                cmd <= shreg;
              end
              sda_oe_out <= 1'b1;
              lstate <= lstate == L_CMD ? L_CMD_ACK : L_WR_ACK;
            end
          end
        end
        L_ADDR_ACK: begin
          if (fall) begin
            bitcnt <= 4'h0;
            sda_oe_out <= rw ? ~tx[7] : 1'b0;
            lstate <= rw ? L_RD : L_CMD;
          end
        end
        L_CMD_ACK: begin
          if (fall) begin
            bitcnt <= 4'h0;
            sda_oe_out <= 1'b0;
            if (cmd == CLEAR_FAULTS_CMD) begin
              clr_tog <= ~clr_tog; // [R13]
              scl_oe_out <= 1'b1;
              lstate <= L_STRETCH;
            end else begin
              lstate <= L_WR;
            end
          end
        end
        L_STRETCH: begin
          // hold the clock until the core has cleared the automatic mask
          if (l_clr_ack == clr_tog) begin
            scl_oe_out <= 1'b0;
            lstate <= L_WR;
          end
        end
        L_WR_ACK: begin
          if (fall) begin
            bitcnt <= 4'h0;
            sda_oe_out <= 1'b0;
            lstate <= L_WR;
          end
        end
        L_RD: begin
          if (rise) begin
            bitcnt <= bitcnt + 4'h1;
            if (tx[7] && !l_sda) begin
              lstate <= L_IDLE; // [R10]
              sda_oe_out <= 1'b0;
            end else if (bitcnt == 4'h7 && ara_sel) begin
              ara_tog <= ~ara_tog; // [R10] [R11]
              ara_sel <= 1'b0;
            end
          end else if (fall) begin
            if (bitcnt == 4'h8) begin
              sda_oe_out <= 1'b0;
              lstate <= L_RD_ACK;
            end else begin
              tx <= {tx[6:0], 1'b1};
              sda_oe_out <= ~tx[6];
            end
          end
        end
        L_RD_ACK: begin
          if (rise) begin
            if (l_sda) begin
              lstate <= L_IDLE;
            end else begin
              tx <= (!ara_sel && cmd == ALERT_MASK_CMD && rw) ? fault_alert_enable_mask[15:8] : UNMAPPED_READ;
              lstate <= L_ADDR_ACK;
            end
          end
        end
        default: begin
          lstate <= L_IDLE;
        end
      endcase
    end
  end

  // low byte first, the word takes effect when the high byte lands
  always_ff @(posedge link_clk_in) begin
    if (!l_rst_b) begin
      fault_alert_enable_mask <= ALERT_MASK_RESET;
      mask_lo <= 8'h00;
      wr_idx <= 1'b0;
      mask_tog <= 1'b0;
    end else if (lstate == L_CMD_ACK) begin
      wr_idx <= 1'b0;
    end else if (lstate == L_WR && fall && bitcnt == 4'h8 && !abort_c && !stop_c && !start_c) begin
      if (!wr_idx) begin
        mask_lo <= shreg;
        wr_idx <= 1'b1;
      end else if (cmd == ALERT_MASK_CMD) begin
        fault_alert_enable_mask <= {shreg, mask_lo}; // [R9]
        mask_tog <= ~mask_tog;
      end
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence s_ara_taken;
    ara_evt && !clr_evt;
  endsequence
  sequence s_faults_steady;
    $stable(fault_in);
  endsequence

  a_ara_release: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R11]
      s_ara_taken ##1 s_faults_steady |=> !alert_on)
    else $error("alert still driven after a won alert response read");
  a_auto_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R12]
      !clr_evt |=> (auto_alert_suppress & $past(auto_alert_suppress)) == $past(auto_alert_suppress))
    else $error("automatic mask bit dropped without a clear");
  a_clear_auto: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R13]
      clr_evt && !ara_evt |=> auto_alert_suppress == 16'h0000)
    else $error("clear-faults did not empty the automatic mask");
  a_mask_full: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R9]
      (mask_c == 16'hffff) [*2] |-> !alert_on)
    else $error("alert driven while every source is masked");
  a_alert_drive: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R14]
      (|(fault_in & ~mask_c & ~auto_alert_suppress)) [*2] |-> host_alert_line_oe_out && !host_alert_line_out)
    else $error("unmasked fault does not pull the alert line low");
  a_timeout_abort: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R6]
      c_busy && !c_scl && low_cnt == TIMEOUT_CYCLES - 1 |=> abort_tog != $past(abort_tog))
    else $error("clock-low time-out did not reset the link");
  a_stretch_cap: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R7]
      c_busy && c_stretch && stretch_cnt == STRETCH_CYCLES - 1 |=> abort_tog != $past(abort_tog))
    else $error("stretch limit reached without a link reset");
  a_abort_release: assert property (@(posedge link_clk_in) disable iff (!l_rst_b) // [R7]
      abort_c |=> !scl_oe_out && !sda_oe_out && lstate == L_IDLE)
    else $error("bus lines held after a link reset");
  a_ara_arbit: assert property (@(posedge link_clk_in) disable iff (!l_rst_b) // [R10]
      lstate == L_RD && rise && tx[7] && !l_sda && !abort_c && !stop_c && !start_c
      |=> lstate == L_IDLE && !sda_oe_out && $stable(ara_tog))
    else $error("lost arbitration still counted or still driving");
  a_addr_rw: assert property (@(posedge link_clk_in) disable iff (!l_rst_b) // [R3]
      lstate == L_ADDR && fall && bitcnt == 4'h8 && own_hit && !abort_c && !stop_c && !start_c
      |=> sda_oe_out && lstate == L_ADDR_ACK && rw == $past(shreg[0]))
    else $error("own address not acknowledged with the direction bit kept");
endmodule

// *** verilog/smbus_alert_pkg.sv ***
// shared constants, types and helper functions for the address-strap and alert front end
package smbus_alert_pkg;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned SLAVE_STRETCH_MS = 25;
  // the figures are the least time-out, so the counts round down to stay inside 35 ms
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned STRETCH_CYC = SLAVE_STRETCH_MS * (CLK_HZ / 1000);
  localparam logic [4:0] STRAP_SETTLE_CYC = 5'h10;

  // --------------------------------------------------------------------------
  // command codes, bus addresses, reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] ALERT_MASK_CMD = 8'hd8;
  localparam logic [7:0] CLEAR_FAULTS_CMD = 8'h03;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  localparam logic [15:0] ALERT_MASK_RESET = 16'h0000;
  localparam logic [6:0] ADDR_FIRST_BASE = 7'h40;
  localparam logic [6:0] ADDR_SECOND_BASE = 7'h10;
  localparam logic [6:0] ADDR_THIRD_BASE = 7'h50;
  localparam logic [4:0] IDX_SECOND = 5'h08;
  localparam logic [4:0] IDX_THIRD = 5'h10;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {LVL_FLOAT, LVL_LOW, LVL_HIGH} strap_level_t;
  typedef enum logic [1:0] {S_WAIT, S_DRV_HI, S_DRV_LO, S_DONE} strap_state_t;
  typedef enum logic [3:0] {L_IDLE, L_ADDR, L_ADDR_ACK, L_CMD, L_CMD_ACK, L_WR, L_WR_ACK,
                            L_RD, L_RD_ACK, L_STRETCH} link_state_t;
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } slave_addr_t;

  // --------------------------------------------------------------------------
  // strap decoding
  // --------------------------------------------------------------------------
  // a pin that follows our own weak drive both ways is floating
  function automatic strap_level_t pin_level(input logic seen_hi, input logic seen_lo);
    if (seen_hi && !seen_lo) begin
      return LVL_FLOAT;
    end else if (seen_hi) begin
      return LVL_HIGH;
    end else if (!seen_lo) begin
      return LVL_LOW;
    end else begin
      return LVL_FLOAT;
    end
  endfunction

  function automatic logic [4:0] strap_index(input strap_level_t hi, input strap_level_t mid,
                                             input strap_level_t lo);
    logic [4:0] h;
    logic [4:0] m;
    logic [4:0] l;
    h = 5'(hi);
    m = 5'(mid);
    l = 5'(lo);
    return 5'(h * 5'h09 + m * 5'h03 + l);
  endfunction

  function automatic logic [6:0] strap_addr(input logic [4:0] idx);
    if (idx < IDX_SECOND) begin
      return ADDR_FIRST_BASE + {2'h0, idx};
    end else if (idx < IDX_THIRD) begin
      return ADDR_SECOND_BASE + {2'h0, 5'(idx - IDX_SECOND)};
    end else begin
      return ADDR_THIRD_BASE + {2'h0, 5'(idx - IDX_THIRD)};
    end
  endfunction

endpackage

// *** verilog/strap_addr_decode.sv ***
// tri-level strap probe and slave address decoder
`timescale 1ns/1ps
module strap_addr_decode
  import smbus_alert_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ready_in,
  input wire logic [2:0] strap_pin_in,
  output logic [2:0] strap_pin_out,
  output logic [2:0] strap_pin_oe_out,
  output slave_addr_t slave_addr_out
);
  strap_state_t state;
  logic [4:0] cnt;
  logic [2:0] seen_hi;
  logic [2:0] pins;

  bit_sync #(.W(3)) pin_sync (.clk_in(clk_in), .d_in(strap_pin_in), .q_out(pins));

  // pins are probed by driving each way; a tie overrides us, a floating pin follows
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= S_WAIT;
      cnt <= 5'h00;
      seen_hi <= 3'h0;
      strap_pin_out <= 3'h0;
      strap_pin_oe_out <= 3'h0;
      slave_addr_out <= '0;
    end else if (!ready_in) begin
      state <= S_WAIT; // [R2]
      strap_pin_oe_out <= 3'h0;
      slave_addr_out.valid <= 1'b0;
    end else begin
      case (state)
        S_WAIT: begin
          state <= S_DRV_HI;
          strap_pin_out <= 3'h7;
          strap_pin_oe_out <= 3'h7;
          cnt <= 5'h00;
        end
        S_DRV_HI: begin
          if (cnt == STRAP_SETTLE_CYC - 5'h01) begin
            seen_hi <= pins;
            strap_pin_out <= 3'h0;
            cnt <= 5'h00;
            state <= S_DRV_LO;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        S_DRV_LO: begin
          if (cnt == STRAP_SETTLE_CYC - 5'h01) begin
            slave_addr_out.addr <= strap_addr(strap_index(pin_level(seen_hi[2], pins[2]),
                                                          pin_level(seen_hi[1], pins[1]),
                                                          pin_level(seen_hi[0], pins[0]))); // [R1] [R4]
            slave_addr_out.valid <= 1'b1;
            strap_pin_oe_out <= 3'h0;
            state <= S_DONE;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        default: begin
          state <= S_DONE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_strap_gate: assert property ($rose(slave_addr_out.valid) |-> ready_in && $past(ready_in, 2)) // [R2]
    else $error("strap address became valid without enable and supplies ready");
  a_addr_legal: assert property (slave_addr_out.valid |-> slave_addr_out.addr inside
      {[7'h40:7'h47], [7'h10:7'h17], [7'h50:7'h5a]}) // [R4]
    else $error("decoded slave address outside the strap table");
endmodule
